// [logic/adc_auto_sequencer.sv]
`timescale 1ns/1ps
// Summary of operation
// [R1] all logic runs on one internal trimmed rc clock
// [R2] converter yields an 8-bit result per channel
// [R3] sequencer picks each mux input, converts and stores result autonomously
// [R4] reads never stall conversion; latest completed result is returned
// [R5] 8 us per conversion, boost every 16 us, battery and temp every 32 us; a served led slot takes the temp slot 3 instead
// [R6] boost slot alternates with others; led request slots at fixed points
// [R7] nonzero forced interval raises led request every n sequences; zero disables
// [R8] control falling edge raises led request after a phase delay
// [R9] control high updates on-voltage and voltage; low updates voltage only
// [R10] one led request served at a time; full sequence before next accepted
// [R11] priority flag starts at channel 1 and after each serve points to the channel not served
// [R12] every result carries odd parity in bit 8 over bits 7..0
// [R13] battery full scale is 40 volts
// [R14] boost full scale is 70 volts
// [R15] temperature in celsius equals code minus 20, applied by host
// [R16] temperature result is fed to thermal warning and shutdown logic
// [R17] led voltage and on-voltage full scale is 70 volts
// [R18] constant control input still measured at forced interval rate
module adc_auto_sequencer #(
  parameter int CONV_CYC = adc_seq_pkg::CONV_CYCLES,
  parameter int DELAY_CYC = adc_seq_pkg::PHASE_DELAY_CYCLES
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // configuration
  input wire logic [adc_seq_pkg::FORCE_W-1:0] forced_interval_count_in,
  // channel control pins, asynchronous
  input wire logic [1:0] channel_control_pin_in,
  // analog converter front end
  output logic [2:0] mux_select_out,
  output logic sample_out,
  input wire logic comparator_in,
  // results
  output adc_seq_pkg::result_bank_t results_out,
  output logic [adc_seq_pkg::RES_W-1:0] thermal_temp_out,
  output logic thermal_temp_valid_out
);
  import adc_seq_pkg::*;

  if (CONV_CYC < RES_W + 2) begin : g_conv_chk
    $error("conversion too short for sar bits");
  end
  if (DELAY_CYC < 1) begin : g_dly_chk
    $error("phase delay must be at least one cycle");
  end

  // =====================================
  // pin synchronisers
  logic [1:0] ctl_meta_r, ctl_sync_r, ctl_prev_r;
  always_ff @(posedge core_clk_in) begin // [R1]
    if (reset_in) begin
      ctl_meta_r <= 2'h0;
      ctl_sync_r <= 2'h0;
      ctl_prev_r <= 2'h0;
    end else begin
      ctl_meta_r <= channel_control_pin_in;
      ctl_sync_r <= ctl_meta_r;
      ctl_prev_r <= ctl_sync_r;
    end
  end
  logic [1:0] ctl_fall;
  assign ctl_fall = ctl_prev_r & ~ctl_sync_r;

  // =====================================
  // conversion timer and sar
  localparam int CW = $clog2(CONV_CYC + 1);
  logic [CW-1:0] conv_cnt_r;
  logic [1:0] slot_r;
  logic conv_done;
  assign conv_done = (conv_cnt_r == CW'(CONV_CYC - 1));
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      conv_cnt_r <= '0;
      slot_r <= 2'h0;
    end else if (conv_done) begin
      conv_cnt_r <= '0; // [R5]
      slot_r <= slot_r + 2'h1;
    end else begin
      conv_cnt_r <= conv_cnt_r + CW'(1);
    end
  end

  // sar steps one bit per cycle from cycle 1; rest of slot settles and stores
  logic [RES_W-1:0] sar_r;
  logic [3:0] bit_idx;
  assign bit_idx = 4'(conv_cnt_r - CW'(1));
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sar_r <= '0;
    end else if (conv_cnt_r == '0) begin
      sar_r <= 8'h80; // [R2]
    end else if (conv_cnt_r <= CW'(RES_W)) begin
      sar_r[RES_W-1-bit_idx] <= comparator_in;
      if (bit_idx < 4'(RES_W - 1)) begin
        sar_r[RES_W-2-bit_idx] <= 1'b1;
      end
    end
  end
  assign sample_out = (conv_cnt_r == '0);

  // =====================================
  // led requests: phase delay per channel, forced interval
  localparam int DW = $clog2(DELAY_CYC + 1);
  logic [1:0][DW-1:0] dly_cnt_r;
  logic [1:0] dly_run_r, pend_r;
  logic [FORCE_W-1:0] seq_cnt_r;
  logic force_tick;
  logic seq_end;
  assign seq_end = conv_done && (slot_r == 2'h3);
  assign force_tick = seq_end && (forced_interval_count_in != '0) &&
                      (seq_cnt_r == forced_interval_count_in - 9'h001); // [R7]
  always_ff @(posedge core_clk_in) begin
    if (reset_in || forced_interval_count_in == '0) begin
      seq_cnt_r <= '0;
    end else if (force_tick) begin
      seq_cnt_r <= '0;
    end else if (seq_end) begin
      seq_cnt_r <= seq_cnt_r + 9'h001;
    end
  end

  // led service state
  logic serving_r, serve_ch_r, prio_r, lockout_r;
  logic serve_start;
  logic [1:0] serve_grant;

  for (genvar c = 0; c < 2; c++) begin : g_req
    always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
        dly_cnt_r[c] <= '0;
        dly_run_r[c] <= 1'b0;
      end else if (ctl_fall[c]) begin
        dly_cnt_r[c] <= '0; // [R8]
        dly_run_r[c] <= 1'b1;
      end else if (dly_run_r[c]) begin
        dly_cnt_r[c] <= dly_cnt_r[c] + DW'(1);
        if (dly_cnt_r[c] == DW'(DELAY_CYC - 1)) begin
          dly_run_r[c] <= 1'b0;
        end
      end
    end
    logic dly_fire;
    assign dly_fire = dly_run_r[c] && (dly_cnt_r[c] == DW'(DELAY_CYC - 1));
    // set wins over the clear by grant
    always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
        pend_r[c] <= 1'b0;
      end else if (dly_fire || force_tick) begin
        pend_r[c] <= 1'b1; // [R18]
      end else if (serve_grant[c]) begin
        pend_r[c] <= 1'b0;
      end
    end
  end

  // led slot at fixed point: slot 3 replaces the temperature slot when a request is granted
  assign serve_start = conv_done && (slot_r == 2'h2) && !lockout_r && (pend_r != 2'h0); // [R6]
  logic pick;
  assign pick = (pend_r == 2'h3) ? prio_r : pend_r[1]; // [R11]
  assign serve_grant = serve_start ? (pick ? 2'h2 : 2'h1) : 2'h0;

  logic [1:0] lock_slot_r;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      serving_r <= 1'b0;
      serve_ch_r <= 1'b0;
      prio_r <= 1'b0; // [R11]
      lockout_r <= 1'b0;
      lock_slot_r <= 2'h0;
    end else begin
      if (serve_start) begin
        serving_r <= 1'b1;
        serve_ch_r <= pick;
        prio_r <= ~pick; // [R11]
        lockout_r <= 1'b1; // [R10]
        lock_slot_r <= 2'h0;
      end else if (conv_done && serving_r) begin
        serving_r <= 1'b0;
      end
      if (lockout_r && conv_done && !serve_start) begin
        lock_slot_r <= lock_slot_r + 2'h1;
        if (lock_slot_r == 2'h3) begin
          lockout_r <= 1'b0; // [R10]
        end
      end
    end
  end

  // =====================================
  // slot schedule
  mux_ch_t cur_ch;
  always_comb begin
    unique case (slot_r)
      2'h0: cur_ch = CH_BOOST; // [R6]
      2'h1: cur_ch = CH_BATT;
      2'h2: cur_ch = CH_BOOST;
      2'h3: cur_ch = serving_r ? (serve_ch_r ? CH_LED2 : CH_LED1) : CH_TEMP;
    endcase
  end
  assign mux_select_out = cur_ch; // [R3]

  // control level when conversion starts decides on-voltage update
  logic ctl_at_sample_r;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ctl_at_sample_r <= 1'b0;
    end else if (sample_out) begin
      ctl_at_sample_r <= ctl_sync_r[serve_ch_r];
    end
  end

  // =====================================
  // result store; reads see registers directly, never stall
  logic [REG_W-1:0] word;
  assign word = {~^sar_r, sar_r}; // [R12]
  result_bank_t bank_r;
  logic temp_stb_r;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      bank_r <= {7{RESULT_RST}};
      temp_stb_r <= 1'b0;
    end else begin
      temp_stb_r <= 1'b0;
      if (conv_done) begin
        unique case (cur_ch)
          CH_BOOST: bank_r.boost_voltage_result <= word; // [R14]
          CH_BATT: bank_r.battery_voltage_result <= word; // [R13]
          CH_TEMP: begin
            bank_r.die_temperature_result <= word; // [R15]
            temp_stb_r <= 1'b1;
          end
          CH_LED1: begin
            bank_r.led_voltage_result_1 <= word; // [R17]
            if (ctl_at_sample_r) bank_r.led_on_voltage_result_1 <= word; // [R9]
          end
          CH_LED2: begin
            bank_r.led_voltage_result_2 <= word; // [R17]
            if (ctl_at_sample_r) bank_r.led_on_voltage_result_2 <= word; // [R9]
          end
          default: bank_r <= bank_r;
        endcase
      end
    end
  end
  assign results_out = bank_r; // [R4]
  assign thermal_temp_out = bank_r.die_temperature_result[RES_W-1:0]; // [R16]
  assign thermal_temp_valid_out = temp_stb_r;

  // =====================================
  // assertions
  property p_parity;
    @(posedge core_clk_in) disable iff (reset_in) ^results_out.boost_voltage_result == 1'b1;
  endproperty
  a_parity: assert property (p_parity) else $error("boost result parity not odd"); // [R12]

  property p_slot_len;
    @(posedge core_clk_in) disable iff (reset_in) sample_out |=> !sample_out [*8];
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("conversion slot too short"); // [R5]

  property p_boost_alt;
    @(posedge core_clk_in) disable iff (reset_in) (slot_r == 2'h0 || slot_r == 2'h2) |-> cur_ch == CH_BOOST;
  endproperty
  a_boost_alt: assert property (p_boost_alt) else $error("boost slot misplaced"); // [R6]

  property p_one_grant;
    @(posedge core_clk_in) disable iff (reset_in) serve_grant != 2'h3;
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("two led channels granted"); // [R10]

  property p_lockout;
    @(posedge core_clk_in) disable iff (reset_in) serve_start |=> lockout_r && !serve_start;
  endproperty
  a_lockout: assert property (p_lockout) else $error("new led request accepted too early"); // [R10]

  property p_prio;
    @(posedge core_clk_in) disable iff (reset_in) (serve_start && pend_r == 2'h3) |=> prio_r != $past(prio_r);
  endproperty
  a_prio: assert property (p_prio) else $error("priority flag did not toggle"); // [R11]

  property p_delay;
    @(posedge core_clk_in) disable iff (reset_in) ctl_fall[0] |=> dly_run_r[0];
  endproperty
  a_delay: assert property (p_delay) else $error("falling edge did not start phase delay"); // [R8]

  property p_force;
    @(posedge core_clk_in) disable iff (reset_in) force_tick |=> pend_r == 2'h3;
  endproperty
  a_force: assert property (p_force) else $error("forced request not raised"); // [R7]

  property p_store;
    @(posedge core_clk_in) disable iff (reset_in)
      (conv_done && cur_ch == CH_BATT) |=> results_out.battery_voltage_result == $past(word);
  endproperty
  a_store: assert property (p_store) else $error("battery result not stored"); // [R3]

  property p_parity_all;
    @(posedge core_clk_in) disable iff (reset_in)
      ^results_out.led_on_voltage_result_1 && ^results_out.led_on_voltage_result_2 &&
      ^results_out.led_voltage_result_1 && ^results_out.led_voltage_result_2 &&
      ^results_out.battery_voltage_result && ^results_out.die_temperature_result;
  endproperty
  a_parity_all: assert property (p_parity_all) else $error("result parity not odd"); // [R12]

  property p_on_store;
    @(posedge core_clk_in) disable iff (reset_in)
      (conv_done && cur_ch == CH_LED1 && ctl_at_sample_r) |=> results_out.led_on_voltage_result_1 == $past(word);
  endproperty
  a_on_store: assert property (p_on_store) else $error("on-voltage not stored with control high"); // [R9]

  property p_on_hold;
    @(posedge core_clk_in) disable iff (reset_in)
      (conv_done && cur_ch == CH_LED2 && !ctl_at_sample_r) |=> $stable(results_out.led_on_voltage_result_2);
  endproperty
  a_on_hold: assert property (p_on_hold) else $error("on-voltage changed with control low"); // [R9]

  property p_temp_feed;
    @(posedge core_clk_in) disable iff (reset_in) temp_stb_r |-> thermal_temp_out == $past(word[RES_W-1:0]);
  endproperty
  a_temp_feed: assert property (p_temp_feed) else $error("thermal path missed new temperature"); // [R16]

  property p_hold_results;
    @(posedge core_clk_in) disable iff (reset_in) !conv_done |=> $stable(results_out);
  endproperty
  a_hold_results: assert property (p_hold_results) else $error("result changed outside a store"); // [R4]

  property p_next_sample;
    @(posedge core_clk_in) disable iff (reset_in) conv_done |=> sample_out;
  endproperty
  a_next_sample: assert property (p_next_sample) else $error("next conversion did not start"); // [R5]

  // refused requests must wait, not vanish
  property p_pend_kept;
    @(posedge core_clk_in) disable iff (reset_in) lockout_r |=> (pend_r & $past(pend_r)) == $past(pend_r);
  endproperty
  a_pend_kept: assert property (p_pend_kept) else $error("request lost during lockout"); // [R10]

  property p_fire;
    @(posedge core_clk_in) disable iff (reset_in) (dly_run_r[1] && dly_cnt_r[1] == DW'(DELAY_CYC - 1)) |=> pend_r[1];
  endproperty
  a_fire: assert property (p_fire) else $error("phase delay expiry raised no request"); // [R8]

  c_led1: cover property (@(posedge core_clk_in) disable iff (reset_in) serve_grant == 2'h1);
  c_led2: cover property (@(posedge core_clk_in) disable iff (reset_in) serve_grant == 2'h2);
  c_both: cover property (@(posedge core_clk_in) disable iff (reset_in) serve_start && pend_r == 2'h3);
  c_temp: cover property (@(posedge core_clk_in) disable iff (reset_in) temp_stb_r);
endmodule

// [logic/adc_seq_pkg.sv]
package adc_seq_pkg;
  // =====================================
  // clock and timing
  localparam int CLK_MHZ = 250;
  localparam int CONV_TIME_NS = 8000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int SLOTS_PER_SEQ = 4;
  localparam int SEQ_CYCLES = CONV_CYCLES * SLOTS_PER_SEQ;
  localparam int PHASE_DELAY_NS = 8000;
  localparam int PHASE_DELAY_CYCLES = (PHASE_DELAY_NS * CLK_MHZ) / 1000;
  // =====================================
  // result format
  localparam int RES_W = 8;
  localparam int PAR_BIT = 8;
  localparam int REG_W = 9;
  localparam int FORCE_W = 9;
  localparam logic [REG_W-1:0] RESULT_RST = 9'h100;
  localparam int TEMP_OFFSET = 20;
  localparam int VBB_FULL_SCALE_V = 40;
  localparam int VHV_FULL_SCALE_V = 70;
  // =====================================
  // mux channels
  typedef enum logic [2:0] {
    CH_BOOST, CH_BATT, CH_TEMP, CH_LED1, CH_LED2
  } mux_ch_t;

  typedef struct packed {
    logic [REG_W-1:0] led_on_voltage_result_1;
    logic [REG_W-1:0] led_on_voltage_result_2;
    logic [REG_W-1:0] led_voltage_result_1;
    logic [REG_W-1:0] led_voltage_result_2;
    logic [REG_W-1:0] battery_voltage_result;
    logic [REG_W-1:0] boost_voltage_result;
    logic [REG_W-1:0] die_temperature_result;
  } result_bank_t;
endpackage

// [testbench/sar_front_model.sv]
`timescale 1ns/1ps
// ==========================================
// analog front end answering sar trials
module sar_front_model (
  // clock
  input wire logic clk_in,
  // converter side
  input wire logic sample_in,
  input wire logic [2:0] mux_in,
  input wire logic [39:0] codes_in,
  output logic comparator_out
);
  logic [7:0] held_r;
  logic [3:0] bit_r;
  initial begin
    comparator_out = 1'b0;
    held_r = 8'h00;
    bit_r = 4'hF;
  end
  // code frozen at sample so a later change cannot tear the trial
  always @(posedge clk_in) begin
    if (sample_in) begin
      held_r <= codes_in[8*mux_in +: 8];
      comparator_out <= codes_in[8*mux_in+7];
      bit_r <= 4'h6;
    end else if (bit_r != 4'hF) begin
      comparator_out <= held_r[bit_r[2:0]];
      bit_r <= bit_r - 4'h1;
    end else begin
      // outside the trial window the line carries no meaning
      comparator_out <= ~comparator_out;
    end
  end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import adc_seq_pkg::*;
  localparam int CONV = 12;
  localparam int DLY = 2;
  // ==========================================
  // stimulus and design
  logic clk, rst, cmp, smp, tvalid;
  logic [8:0] force_n;
  logic [1:0] ctrl;
  logic [2:0] mux, want;
  logic [39:0] codes;
  logic [7:0] ttemp, pcode;
  result_bank_t res;
  logic [8:0] exp_r [7];
  int failures, total_checks, cycles, slot, leds, last, pidx, pon, alt;
  adc_auto_sequencer #(.CONV_CYC(CONV), .DELAY_CYC(DLY)) adc_auto_sequencer_i (
    .core_clk_in(clk), .reset_in(rst), .forced_interval_count_in(force_n),
    .channel_control_pin_in(ctrl), .mux_select_out(mux), .sample_out(smp),
    .comparator_in(cmp), .results_out(res), .thermal_temp_out(ttemp),
    .thermal_temp_valid_out(tvalid));
  sar_front_model sar_front_model_i (
    .clk_in(clk), .sample_in(smp), .mux_in(mux), .codes_in(codes), .comparator_out(cmp));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================
  // checking
  function automatic logic [8:0] par(input logic [7:0] c);
    return {~^c, c};
  endfunction
  task automatic check(input logic [8:0] seen, input logic [8:0] want_v);
    total_checks++;
    if (seen !== want_v) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want_v);
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // reference model, one step per slot
  // limit sits well above the planned run of about 1400 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      failures++;
      stop_test;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      foreach (exp_r[i]) exp_r[i] = 9'h100;
      slot = 0;
      pidx = -1;
      leds = 0;
      last = -100;
    end else if (smp) begin
      if (pidx >= 0) begin
        exp_r[pidx] = par(pcode);
        if (pon != 0) exp_r[pidx-2] = par(pcode);
      end
      for (int i = 0; i < 7; i++) check(res[62-9*i -: 9], exp_r[i]);
      check({8'h00, tvalid}, {8'h00, pidx == 6});
      if (slot % 4 == 3 && (mux == CH_LED1 || mux == CH_LED2)) begin
        // a whole boost, battery, boost, temperature round between led slots
        check({8'h00, slot - last >= 8}, 9'h001);
        if (alt != 0) begin
          check({6'h00, mux}, {6'h00, want});
          want = (want == CH_LED1) ? CH_LED2 : CH_LED1;
        end
        leds++;
        last = slot;
      end else begin
        check({6'h00, mux}, slot % 4 == 3 ? CH_TEMP : (slot % 2 != 0 ? CH_BATT : CH_BOOST));
      end
      pidx = mux == CH_BOOST ? 5 : mux == CH_BATT ? 4 : mux == CH_TEMP ? 6 : mux == CH_LED1 ? 2 : 3;
      pon = (mux == CH_LED1 && ctrl[0]) || (mux == CH_LED2 && ctrl[1]);
      pcode = codes[8*mux +: 8];
      codes <= {8'($urandom), 32'($urandom)};
      slot++;
    end
    if (!rst && tvalid) check({1'b0, ttemp}, exp_r[6] & 9'h0FF);
    if (!rst && !smp) check({8'h00, tvalid}, 9'h000);
  end
  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    force_n = 9'h000;
    ctrl = 2'b00;
    codes = 40'h00_0000_0000;
    want = CH_LED1;
    {cycles, failures, total_checks, alt} = 0;
    void'($urandom(86823));
    @(posedge clk);
    force_n <= 9'($urandom_range(3, 1));
    ctrl <= 2'b01;
    alt = 1;
    repeat (15) @(posedge clk);
    rst <= 1'b0;
    // constant control levels rely on forcing alone
    repeat (16*4*CONV) @(posedge clk);
    check(9'(leds >= 16 / (force_n + 1)), 9'h001);
    rst <= 1'b1;
    alt = 0;
    force_n <= 9'h000;
    ctrl <= 2'b11;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (6*4*CONV) @(posedge clk);
    check(9'(leds), 9'h000);
    want = CH_LED2;
    alt = 1;
    ctrl <= 2'b01;
    repeat (3*4*CONV) @(posedge clk);
    check(9'(leds), 9'h001);
    // then channel 1 falls on its own
    ctrl <= 2'b00;
    repeat (3*4*CONV) @(posedge clk);
    check(9'(leds), 9'h002);
    stop_test;
  end
endmodule
